// >>> pin_mux_pkg.sv
// pin mux package: register word addresses, field layout, reset values
// assumes a 16-bit cpu i/o port with word addresses
package pin_mux_pkg;
	// ========================================
	// register word addresses
	localparam logic [15:0] EXT_BUS_SELECT_ADDR = 16'h1c00;
	localparam logic [15:0] PULLDOWN_INHIBIT_1_ADDR = 16'h1c17;
	localparam logic [15:0] PULLDOWN_INHIBIT_2_ADDR = 16'h1c18;
	localparam logic [15:0] PULLDOWN_INHIBIT_3_ADDR = 16'h1c19;
	// ========================================
	// select register field positions
	localparam int ADDR_ROUTE_LSB = 0;
	localparam int SERIAL0_ROUTE_LSB = 8;
	localparam int SERIAL1_ROUTE_LSB = 10;
	localparam int PARALLEL_ROUTE_LSB = 12;
	// ========================================
	// reset values
	localparam logic [15:0] EXT_BUS_SELECT_RESET = 16'h0000;
	localparam logic [15:0] PULLDOWN_INHIBIT_RESET = 16'h0000;
	// ========================================
	// route codes
	localparam logic [1:0] SERIAL_ROUTE_CARD = 2'h0;
	localparam logic [1:0] SERIAL_ROUTE_AUDIO = 2'h1;
	localparam logic [1:0] SERIAL_ROUTE_GPIO = 2'h2;
	localparam logic [2:0] PARALLEL_ROUTE_DISPLAY = 3'h0;
	localparam logic [2:0] PARALLEL_ROUTE_GPIO = 3'h1;
	localparam logic [2:0] PARALLEL_ROUTE_MIXED = 3'h2;
	localparam logic [2:0] PARALLEL_ROUTE_AUDIO = 3'h3;
	localparam logic [0:0] ADDR_ROUTE_EMIF = 1'h0;
endpackage

// >>> gpio_pin_mux_pulldown.sv
// pad routing and internal pulldown control for 32 shared pads
// assumes pads resolved outside from out/oe; pad inputs are asynchronous
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - all logic here runs on the system clock only.
// - thirty-two general pins, 31 down to 0, each input or output.
// - one select register at 0x1c00 chooses every shared pad function.
// - new routing takes effect one cycle after the select register takes the write.
// - every pad is shared and has a switchable internal pulldown.
// - pulldowns are set by inhibit registers at 0x1c17, 0x1c18, 0x1c19.
// - pins 0-5 routed by the serial port 0 field.
// - pins 6-11 routed by the serial port 1 field.
// - pins 12-20 and 27-31 routed by the parallel port field.
// - pins 21-26 each routed by its own address-line bit.
// - pulldowns of pins 0-11 follow the first inhibit register.
// - pulldowns of pins 21-26 follow the second inhibit register.
// - pulldowns of pins 12-20 and 27-31 follow the third inhibit register.
// - only hardware reset restores defaults; all pins default to input.
module gpio_pin_mux_pulldown (
	// clock and hardware reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// cpu i/o port
	input wire logic [15:0] io_addr_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [15:0] io_wdata_i,
	output logic [15:0] io_rdata_o,
	// general pin core side
	input wire logic [31:0] general_pins_out_i,
	input wire logic [31:0] general_pins_oe_i,
	output logic [31:0] general_pins_in_o,
	// alternate functions per pad: card, audio, display/emif, mixed
	input wire logic [31:0] card_out_i,
	input wire logic [31:0] card_oe_i,
	output logic [31:0] card_in_o,
	input wire logic [31:0] audio_out_i,
	input wire logic [31:0] audio_oe_i,
	output logic [31:0] audio_in_o,
	input wire logic [31:0] main_out_i,
	input wire logic [31:0] main_oe_i,
	output logic [31:0] main_in_o,
	input wire logic [31:0] mixed_out_i,
	input wire logic [31:0] mixed_oe_i,
	output logic [31:0] mixed_in_o,
	// pads
	input wire logic [31:0] pad_i,
	output logic [31:0] pad_o,
	output logic [31:0] pad_oe_o,
	output logic [31:0] internal_pulldown_en_o
);
	// ========================================
	// registers
	logic [15:0] ext_bus_select_q;
	logic [15:0] pulldown_inhibit_1_q;
	logic [15:0] pulldown_inhibit_2_q;
	logic [15:0] pulldown_inhibit_3_q;
	logic [31:0] pad_sync1_q;
	logic [31:0] pad_sync2_q;
	logic [1:0] sel_d [32];
	logic [31:0] inhibit_d;
	logic [1:0] serial_port0_route_field;
	logic [1:0] serial_port1_route_field;
	logic [2:0] parallel_port_route_field;
	logic [5:0] addr_route_bits;

	// register writes; only sys_rst_i clears them, no software reset path
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ext_bus_select_q <= pin_mux_pkg::EXT_BUS_SELECT_RESET;
			pulldown_inhibit_1_q <= pin_mux_pkg::PULLDOWN_INHIBIT_RESET;
			pulldown_inhibit_2_q <= pin_mux_pkg::PULLDOWN_INHIBIT_RESET;
			pulldown_inhibit_3_q <= pin_mux_pkg::PULLDOWN_INHIBIT_RESET;
		end else if (io_wr_i) begin
			if (io_addr_i == pin_mux_pkg::EXT_BUS_SELECT_ADDR) begin
				ext_bus_select_q <= io_wdata_i;
			end
			if (io_addr_i == pin_mux_pkg::PULLDOWN_INHIBIT_1_ADDR) begin
				pulldown_inhibit_1_q <= io_wdata_i;
			end
			if (io_addr_i == pin_mux_pkg::PULLDOWN_INHIBIT_2_ADDR) begin
				pulldown_inhibit_2_q <= io_wdata_i;
			end
			if (io_addr_i == pin_mux_pkg::PULLDOWN_INHIBIT_3_ADDR) begin
				pulldown_inhibit_3_q <= io_wdata_i;
			end
		end
	end

	// read data registered; unmapped addresses read zero
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			io_rdata_o <= 16'h0000;
		end else if (io_rd_i) begin
			unique case (io_addr_i)
				pin_mux_pkg::EXT_BUS_SELECT_ADDR: io_rdata_o <= ext_bus_select_q;
				pin_mux_pkg::PULLDOWN_INHIBIT_1_ADDR: io_rdata_o <= pulldown_inhibit_1_q;
				pin_mux_pkg::PULLDOWN_INHIBIT_2_ADDR: io_rdata_o <= pulldown_inhibit_2_q;
				pin_mux_pkg::PULLDOWN_INHIBIT_3_ADDR: io_rdata_o <= pulldown_inhibit_3_q;
				default: io_rdata_o <= 16'h0000;
			endcase
		end
	end

	// ========================================
	// field decode
	assign serial_port0_route_field = ext_bus_select_q[pin_mux_pkg::SERIAL0_ROUTE_LSB +: 2];
	assign serial_port1_route_field = ext_bus_select_q[pin_mux_pkg::SERIAL1_ROUTE_LSB +: 2];
	assign parallel_port_route_field = ext_bus_select_q[pin_mux_pkg::PARALLEL_ROUTE_LSB +: 3];
	assign addr_route_bits = ext_bus_select_q[pin_mux_pkg::ADDR_ROUTE_LSB +: 6];

	// per-pad source: 0 card/display/emif, 1 audio, 2 general pin, 3 mixed
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			sel_d[i] = 2'h2;
			if (i <= 5) begin
				unique case (serial_port0_route_field)
					pin_mux_pkg::SERIAL_ROUTE_CARD: sel_d[i] = 2'h0;
					pin_mux_pkg::SERIAL_ROUTE_AUDIO: sel_d[i] = (i <= 3) ? 2'h1 : 2'h2;
					default: sel_d[i] = 2'h2;
				endcase
			end else if (i <= 11) begin
				unique case (serial_port1_route_field)
					pin_mux_pkg::SERIAL_ROUTE_CARD: sel_d[i] = 2'h0;
					pin_mux_pkg::SERIAL_ROUTE_AUDIO: sel_d[i] = (i <= 9) ? 2'h1 : 2'h2;
					default: sel_d[i] = 2'h2;
				endcase
			end else if (i >= 21 && i <= 26) begin
				// one route bit per address line
				sel_d[i] = (addr_route_bits[i-21] == pin_mux_pkg::ADDR_ROUTE_EMIF)
					? 2'h0 : 2'h2;
			end else begin
				unique case (parallel_port_route_field)
					pin_mux_pkg::PARALLEL_ROUTE_DISPLAY: sel_d[i] = 2'h0;
					pin_mux_pkg::PARALLEL_ROUTE_MIXED: sel_d[i] = (i >= 18) ? 2'h3 : 2'h2;
					pin_mux_pkg::PARALLEL_ROUTE_AUDIO: sel_d[i] = (i >= 18) ? 2'h1 : 2'h2;
					default: sel_d[i] = 2'h2;
				endcase
			end
		end
	end

	// inhibit bit per pad: pins 0-11 reg1, 21-26 reg2, rest reg3 in order
	always_comb begin
		inhibit_d[11:0] = pulldown_inhibit_1_q[11:0];
		inhibit_d[26:21] = pulldown_inhibit_2_q[5:0];
		inhibit_d[20:12] = pulldown_inhibit_3_q[8:0];
		inhibit_d[31:27] = pulldown_inhibit_3_q[13:9];
	end

	// two-flop synchroniser on asynchronous pad inputs
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pad_sync1_q <= 32'h00000000;
			pad_sync2_q <= 32'h00000000;
		end else begin
			pad_sync1_q <= pad_i;
			pad_sync2_q <= pad_sync1_q;
		end
	end

	// pad drive registered from current select: route lands next cycle
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pad_o <= 32'h00000000;
			pad_oe_o <= 32'h00000000;
			internal_pulldown_en_o <= 32'hffffffff;
			general_pins_in_o <= 32'h00000000;
			card_in_o <= 32'h00000000;
			audio_in_o <= 32'h00000000;
			main_in_o <= 32'h00000000;
			mixed_in_o <= 32'h00000000;
		end else begin
			for (int i = 0; i < 32; i++) begin
				internal_pulldown_en_o[i] <= ~inhibit_d[i];
				unique case (sel_d[i])
					2'h0: begin
						// card owns 0-11, display/emif the rest; never merge the two
						pad_o[i] <= (i <= 11) ? card_out_i[i] : main_out_i[i];
						pad_oe_o[i] <= (i <= 11) ? card_oe_i[i] : main_oe_i[i];
					end
					2'h1: begin
						pad_o[i] <= audio_out_i[i];
						pad_oe_o[i] <= audio_oe_i[i];
					end
					2'h2: begin
						pad_o[i] <= general_pins_out_i[i];
						pad_oe_o[i] <= general_pins_oe_i[i];
					end
					2'h3: begin
						pad_o[i] <= mixed_out_i[i];
						pad_oe_o[i] <= mixed_oe_i[i];
					end
				endcase
				general_pins_in_o[i] <= (sel_d[i] == 2'h2) & pad_sync2_q[i];
				card_in_o[i] <= (sel_d[i] == 2'h0) & (i <= 11) & pad_sync2_q[i];
				main_in_o[i] <= (sel_d[i] == 2'h0) & (i > 11) & pad_sync2_q[i];
				audio_in_o[i] <= (sel_d[i] == 2'h1) & pad_sync2_q[i];
				mixed_in_o[i] <= (sel_d[i] == 2'h3) & pad_sync2_q[i];
			end
		end
	end

	// ========================================
	// checks
	property p_write_routes_next;
		@(posedge clk_i) disable iff (sys_rst_i)
		(io_wr_i && io_addr_i == pin_mux_pkg::EXT_BUS_SELECT_ADDR) |=> (ext_bus_select_q == $past(io_wdata_i));
	endproperty
	a_write_routes_next: assert property (p_write_routes_next) else $error("select write lost");

	property p_gpio_route;
		@(posedge clk_i) disable iff (sys_rst_i)
		(serial_port0_route_field == pin_mux_pkg::SERIAL_ROUTE_GPIO) |=> (pad_oe_o[0] == $past(general_pins_oe_i[0]));
	endproperty
	a_gpio_route: assert property (p_gpio_route) else $error("pin 0 not routed to general pin");

	property p_pulldown_follow;
		@(posedge clk_i) disable iff (sys_rst_i)
		1'b1 |=> (internal_pulldown_en_o[21] == !$past(pulldown_inhibit_2_q[0]));
	endproperty
	a_pulldown_follow: assert property (p_pulldown_follow) else $error("pin 21 pulldown wrong");

	property p_unselected_quiet;
		@(posedge clk_i) disable iff (sys_rst_i)
		(addr_route_bits[0] == pin_mux_pkg::ADDR_ROUTE_EMIF) |=> (general_pins_in_o[21] == 1'b0);
	endproperty
	a_unselected_quiet: assert property (p_unselected_quiet) else $error("unselected input saw pad");

	property p_reset_input;
		@(posedge clk_i) sys_rst_i |=> (pad_oe_o == 32'h00000000);
	endproperty
	a_reset_input: assert property (p_reset_input) else $error("pads driven after reset");

	// display route must not let the card drive leak onto pin 12
	property p_display_drive;
		@(posedge clk_i) disable iff (sys_rst_i)
		(sel_d[12] == 2'h0) |=> (pad_o[12] == $past(main_out_i[12]));
	endproperty
	a_display_drive: assert property (p_display_drive) else $error("pin 12 not driven by display");

	property p_inhibit_readback;
		@(posedge clk_i) disable iff (sys_rst_i)
		(io_rd_i && io_addr_i == pin_mux_pkg::PULLDOWN_INHIBIT_3_ADDR)
			|=> (io_rdata_o == $past(pulldown_inhibit_3_q));
	endproperty
	a_inhibit_readback: assert property (p_inhibit_readback) else $error("inhibit 3 read wrong");
endmodule

`default_nettype wire

// >>> pad_far_side.sv
// far side of the pads: external drivers, pulldown, floating level
// assumes the bench sets the external drive off the clock edge
`timescale 1ns/1ps
`default_nettype none
module pad_far_side (
	// clock
	input wire logic clk_i,
	// device pad side
	input wire logic [31:0] dev_out_i,
	input wire logic [31:0] dev_oe_i,
	input wire logic [31:0] pulldown_i,
	// external drivers
	input wire logic [31:0] ext_en_i,
	input wire logic [31:0] ext_val_i,
	output logic [31:0] pad_i
);
	// ====
	// a released pad without pulldown wanders, so stale values never pass
	logic [31:0] float_q = 32'h0;
	always_ff @(posedge clk_i) begin
		float_q <= ~float_q;
	end
	// device drive, then external drive, then pulldown
	assign pad_i = (dev_oe_i & dev_out_i) | (~dev_oe_i & ext_en_i & ext_val_i)
		| (~dev_oe_i & ~ext_en_i & ~pulldown_i & float_q);
endmodule
`default_nettype wire

// >>> gpio_pin_mux_pulldown_tb_top.sv
// bench for the pad mux: routes, timing, registers, pulldowns
// assumes pad_far_side as the pad-side partner
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_mux_pulldown_tb_top;
	// ====
	// stimulus and observed signals; sources 0..4 are gpio, card, audio, main, mixed
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [15:0] io_addr_i = 16'h0000;
	logic io_wr_i = 1'b0;
	logic io_rd_i = 1'b0;
	logic [15:0] io_wdata_i = 16'h0000;
	logic [15:0] io_rdata_o;
	logic [31:0] src_out [5];
	logic [31:0] src_oe [5];
	logic [31:0] src_in [5];
	logic [31:0] ext_en;
	logic [31:0] ext_val;
	logic [31:0] pad_i;
	logic [31:0] pad_o;
	logic [31:0] pad_oe_o;
	logic [31:0] pd_en;
	int mismatches = 0;
	int checks = 0;
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	gpio_pin_mux_pulldown dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .io_addr_i(io_addr_i),
		.io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
		.general_pins_out_i(src_out[0]), .general_pins_oe_i(src_oe[0]),
		.general_pins_in_o(src_in[0]), .card_out_i(src_out[1]), .card_oe_i(src_oe[1]),
		.card_in_o(src_in[1]), .audio_out_i(src_out[2]), .audio_oe_i(src_oe[2]),
		.audio_in_o(src_in[2]), .main_out_i(src_out[3]), .main_oe_i(src_oe[3]),
		.main_in_o(src_in[3]), .mixed_out_i(src_out[4]), .mixed_oe_i(src_oe[4]),
		.mixed_in_o(src_in[4]), .pad_i(pad_i), .pad_o(pad_o), .pad_oe_o(pad_oe_o),
		.internal_pulldown_en_o(pd_en));
	pad_far_side far (.clk_i(clk_i), .dev_out_i(pad_o), .dev_oe_i(pad_oe_o),
		.pulldown_i(pd_en), .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_i(pad_i));
	// ====
	// shared helpers
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		io_addr_i = a;
		io_wdata_i = d;
		io_wr_i = 1'b1;
		@(negedge clk_i);
		io_wr_i = 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		io_addr_i = a;
		io_rd_i = 1'b1;
		@(negedge clk_i);
		io_rd_i = 1'b0;
		@(negedge clk_i);
		d = io_rdata_o;
	endtask
	task automatic idle();
		for (int s = 0; s < 5; s++) begin
			src_out[s] = 32'h0;
			src_oe[s] = 32'h0;
		end
		ext_en = 32'h0;
		ext_val = 32'h0;
	endtask
	task automatic hw_reset();
		logic [15:0] d;
		idle();
		sys_rst_i = 1'b1;
		repeat (16) @(negedge clk_i);
		sys_rst_i = 1'b0;
		chk("pulldown", 32'hffffffff, pd_en);
		chk("pad_oe", 32'h0, pad_oe_o);
		for (int i = 0; i < 4; i++) begin
			rd((i == 0) ? 16'h1c00 : 16'h1c16 + 16'(i), d);
			chk("reg reset", 32'h0, {16'h0, d});
		end
	endtask
	// owner of pin p: 0 gpio, 1 card, 2 audio, 3 main, 4 mixed, 7 unspecified
	function automatic int route(input logic [15:0] sel, input int p);
		logic [1:0] c;
		logic [2:0] m;
		c = (p < 6) ? sel[9:8] : sel[11:10];
		m = sel[14:12];
		if (p < 12) return (c == 2'h0) ? 1 : (c == 2'h1) ? ((p % 6 < 4) ? 2 : 7) : 0;
		if (p >= 21 && p <= 26) return sel[p-21] ? 0 : 3;
		if (m == 3'h0) return 3;
		if (m == 3'h2 || m == 3'h3) return (p < 18) ? 7 : (m == 3'h2) ? 4 : 2;
		return 0;
	endfunction
	// ====
	// one select write after a hardware reset, so the route is never switched twice
	task automatic route_case(input logic [15:0] sel);
		logic [31:0] m [5];
		logic [31:0] care;
		for (int p = 0; p < 32; p++) begin
			care[p] = route(sel, p) != 7;
			for (int s = 0; s < 5; s++) m[s][p] = route(sel, p) == s;
		end
		hw_reset();
		src_oe[0] = 32'hffffffff;
		// peripheral sources stay quiet over the single select write
		wr(pin_mux_pkg::EXT_BUS_SELECT_ADDR, sel);
		chk("pad_oe early", 32'h0, pad_oe_o);
		repeat (2) @(negedge clk_i);
		chk("pad_oe route", m[0], pad_oe_o & care);
		for (int s = 0; s < 5; s++) begin
			idle();
			src_oe[s] = 32'hffffffff;
			src_out[s] = 32'hffffffff;
			repeat (2) @(negedge clk_i);
			chk("pad_o", m[s], pad_o & care);
			chk("pad_oe", m[s], pad_oe_o & care);
		end
		idle();
		ext_en = 32'hffffffff;
		ext_val = 32'hffffffff;
		repeat (4) @(negedge clk_i);
		for (int s = 0; s < 5; s++) chk("fn_in", m[s], src_in[s] & care);
		chk("pad_oe input", 32'h0, pad_oe_o);
		ext_en = 32'h0;
		repeat (4) @(negedge clk_i);
		chk("pulled low", 32'h0, src_in[0]);
	endtask
	task automatic pulldown_case();
		logic [15:0] v [3];
		logic [15:0] d;
		v = '{16'h0a5a, 16'h0015, 16'h2a5a};
		hw_reset();
		// an idle edge between writes so the strobe never toggles in one step
		for (int i = 0; i < 3; i++) begin
			wr(pin_mux_pkg::PULLDOWN_INHIBIT_1_ADDR + 16'(i), v[i]);
			@(negedge clk_i);
		end
		wr(16'h1c01, 16'hffff);
		rd(16'h1c01, d);
		chk("unmapped", 32'h0, {16'h0, d});
		for (int i = 0; i < 3; i++) begin
			rd(pin_mux_pkg::PULLDOWN_INHIBIT_1_ADDR + 16'(i), d);
			chk("inhibit", {16'h0, v[i]}, {16'h0, d});
		end
		chk("pd_en", ~{v[2][13:9], v[1][5:0], v[2][8:0], v[0][11:0]}, pd_en);
	endtask
	task automatic conclude();
		if (mismatches == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		idle();
		route_case(16'h0000);
		route_case(16'h1a3f);
		route_case(16'h2515);
		route_case(16'h3e2a);
		pulldown_case();
		conclude();
	end
	// watchdog well beyond the expected run
	initial begin
		repeat (5000) @(posedge clk_i);
		mismatches++;
		conclude();
	end
endmodule
`default_nettype wire
